/* File: hdl/rarb_map.svh */
// constants for the ram access arbiter cycle signals block
`ifndef RARB_MAP_SVH
`define RARB_MAP_SVH
`define RARB_ADDR_W      8
`define RARB_CNT_W       16
`define RARB_GNT_HIGH    2'h3
`define RARB_GNT_MID     2'h2
`define RARB_GNT_LOW     2'h1
`define RARB_GNT_HOST    2'h0
`define RARB_CH_HIGH     2
`define RARB_CH_MID      1
`define RARB_CH_LOW      0
`define RARB_REFRESH_DIV 4'h2
`endif

/* File: hdl/rarb_pkg.sv */
// types shared by both ends of the ram access arbiter
package rarb_pkg;
  typedef enum logic [2:0] {
    RARB_OWN_NONE,
    RARB_OWN_HOST,
    RARB_OWN_LOW,
    RARB_OWN_MID,
    RARB_OWN_HIGH
  } rarb_owner_e;
  typedef enum logic [1:0] {
    RARB_IDLE_INACTIVE,
    RARB_IDLE_REFRESH,
    RARB_IDLE_TIMER
  } rarb_idle_e;
endpackage : rarb_pkg

/* File: hdl/rarb_if.sv */
// pin bundle between the arbiter device and its requesters
`timescale 1ns/10ps
interface rarb_if;
  logic       ramClk;
  logic       host_ram_request_n;
  logic       dma_req_low_pri_n;
  logic       dma_req_mid_pri_n;
  logic       dma_req_high_pri_n;
  logic       ackEnable_n;
  logic       grant_code_msb;
  logic       grant_code_lsb;
  logic [7:0] dramMuxAddr;
  logic       rwDevOut;
  logic       rwDevOe;
  logic       rwExtOut;
  logic       rwExtOe;
  logic       stopDevOut;
  logic       stopDevOe;
  logic       stopExtOut;
  logic       stopExtOe;
  // wired line levels, pulled high when nobody drives
  logic       read_write_n;
  logic       stopLine_n;
  assign read_write_n = rwDevOe ? rwDevOut : (rwExtOe ? rwExtOut : 1'b1);
  assign stopLine_n   = stopDevOe ? stopDevOut : (stopExtOe ? stopExtOut : 1'b1);
  modport device (
    input  ramClk, host_ram_request_n, dma_req_low_pri_n, dma_req_mid_pri_n,
    input  dma_req_high_pri_n, read_write_n, stopLine_n,
    output ackEnable_n, grant_code_msb, grant_code_lsb, dramMuxAddr,
    output rwDevOut, rwDevOe, stopDevOut, stopDevOe
  );
  modport requester (
    output ramClk, host_ram_request_n, dma_req_low_pri_n, dma_req_mid_pri_n,
    output dma_req_high_pri_n, rwExtOut, rwExtOe, stopExtOut, stopExtOe,
    input  ackEnable_n, grant_code_msb, grant_code_lsb, dramMuxAddr,
    input  read_write_n, stopLine_n
  );
endinterface : rarb_if

/* File: hdl/rarb_device.sv */
// arbiter device end: priority grant, cycle signalling, dram address mux
`timescale 1ns/10ps
`include "rarb_map.svh"
module rarb_device
  import rarb_pkg::*;
#(
  parameter int CNT_W = `RARB_CNT_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  rarb_if.device                        bus,
  input  wire logic [2:0]               chStart,
  input  wire logic [3*CNT_W-1:0]       chCount,
  input  wire logic [2:0]               chDevRw,
  input  wire logic [2:0]               chDevStop,
  input  wire logic [2:0]               chWrite,
  input  wire logic [2*`RARB_ADDR_W-1:0] rowColAddr,
  input  wire logic [`RARB_ADDR_W-1:0]  refreshAddr,
  input  wire logic [`RARB_ADDR_W-1:0]  timerCount,
  input  wire logic                     timerDue,
  output logic [2:0]                    chEnabled,
  output logic [2:0]                    chDone,
  output rarb_owner_e                   owner
);
  // ==========================================
  // pin synchronisers
  logic [5:0] pinMeta_q;
  logic [5:0] pinSync_q;
  logic       clkSeen_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // ram clock bit resets to its idle low level, so no false rise follows reset
      pinMeta_q <= 6'h1F;
      pinSync_q <= 6'h1F;
    end else begin
      pinMeta_q <= {bus.ramClk, bus.host_ram_request_n, bus.dma_req_low_pri_n,
                    bus.dma_req_mid_pri_n, bus.dma_req_high_pri_n, bus.stopLine_n};
      pinSync_q <= pinMeta_q;
    end
  end
  logic ramClkS;
  logic hostReqS;
  logic lowReqS;
  logic midReqS;
  logic highReqS;
  logic stopS;
  assign {ramClkS, hostReqS, lowReqS, midReqS, highReqS, stopS} = pinSync_q;
  always_ff @(posedge ref_clk) begin
    if (srst) clkSeen_q <= 1'b0;
    else      clkSeen_q <= ramClkS;
  end
  logic cycleEdge;
  assign cycleEdge = ramClkS & ~clkSeen_q;

  // ==========================================
  // channel enables and byte counts
  logic [CNT_W-1:0] count_q [3];
  logic [2:0]       en_q;
  logic [2:0]       lastCyc;
  logic [2:0]       reqLive;
  // a channel ending at this edge must not win the next cycle as well
  assign reqLive = {~highReqS, ~midReqS, ~lowReqS} & en_q & ~chDone;

  // ==========================================
  // priority decision
  rarb_owner_e own_d;
  rarb_owner_e own_q;
  always_comb begin
    own_d = RARB_OWN_NONE;
    // raw pin levels decide priority; a disabled channel still blocks lower ones
    if      (~highReqS) own_d = reqLive[`RARB_CH_HIGH] ? RARB_OWN_HIGH : RARB_OWN_NONE;
    else if (~midReqS)  own_d = reqLive[`RARB_CH_MID] ? RARB_OWN_MID : RARB_OWN_NONE;
    else if (~lowReqS)  own_d = reqLive[`RARB_CH_LOW] ? RARB_OWN_LOW : RARB_OWN_NONE;
    else if (~hostReqS) own_d = RARB_OWN_HOST;
  end

  function automatic int chOf(rarb_owner_e o);
    case (o)
      RARB_OWN_HIGH: chOf = `RARB_CH_HIGH;
      RARB_OWN_MID:  chOf = `RARB_CH_MID;
      RARB_OWN_LOW:  chOf = `RARB_CH_LOW;
      default:       chOf = 3;
    endcase
  endfunction : chOf

  // idle cycle kind: refresh every other idle cycle, timer in the others when due
  rarb_idle_e idle_q;
  logic       refreshTurn_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      own_q         <= RARB_OWN_NONE;
      idle_q        <= RARB_IDLE_INACTIVE;
      refreshTurn_q <= 1'b0;
    end else if (cycleEdge) begin
      own_q <= own_d;
      if (own_d == RARB_OWN_NONE) begin
        refreshTurn_q <= ~refreshTurn_q;
        if (refreshTurn_q)  idle_q <= RARB_IDLE_REFRESH;
        else if (timerDue)  idle_q <= RARB_IDLE_TIMER;
        else                idle_q <= RARB_IDLE_INACTIVE;
      end
    end
  end

  // ==========================================
  // per-channel count, last cycle and disable
  generate
    for (genvar c = 0; c < 3; c++) begin : g_ch
      logic granted;
      assign granted    = (chOf(own_q) == c);
      assign lastCyc[c] = granted && (count_q[c] == '0);
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          en_q[c]    <= 1'b0;
          count_q[c] <= '0;
        end else if (chStart[c]) begin
          en_q[c]    <= 1'b1;
          count_q[c] <= chCount[c*CNT_W +: CNT_W];
        end else if (cycleEdge && granted) begin
          // external stop on a chDevStop channel disables it instead of running the count
          if (lastCyc[c] || (chDevStop[c] && !stopS)) en_q[c] <= 1'b0;
          else count_q[c] <= count_q[c] - 1'b1;
        end
      end
      assign chDone[c] = cycleEdge && granted && (lastCyc[c] || (chDevStop[c] && !stopS));
    end
  endgenerate
  assign chEnabled = en_q;
  assign owner     = own_q;

  // ==========================================
  // cycle outputs
  logic       ackN_q;
  logic [1:0] code_q;
  logic [7:0] addr_q;
  logic       rwOut_q;
  logic       rwOe_q;
  logic       stopOut_q;
  logic       stopOe_q;
  int         ch;
  always_comb ch = chOf(own_q);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ackN_q <= 1'b1;
      code_q <= `RARB_GNT_HOST;
    end else begin
      ackN_q <= (own_q == RARB_OWN_NONE);
      case (own_q)
        RARB_OWN_HIGH: code_q <= `RARB_GNT_HIGH;
        RARB_OWN_MID:  code_q <= `RARB_GNT_MID;
        RARB_OWN_LOW:  code_q <= `RARB_GNT_LOW;
        default:       code_q <= `RARB_GNT_HOST;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) addr_q <= '0;
    else if (own_q == RARB_OWN_NONE)
      addr_q <= (idle_q == RARB_IDLE_TIMER) ? timerCount : refreshAddr;
    else if (ramClkS)
      addr_q <= rowColAddr[2*`RARB_ADDR_W-1:`RARB_ADDR_W];
    else
      addr_q <= rowColAddr[`RARB_ADDR_W-1:0];
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rwOut_q <= 1'b1;
      rwOe_q  <= 1'b1;
    end else if (own_q == RARB_OWN_NONE) begin
      rwOe_q  <= 1'b1;
      rwOut_q <= (idle_q != RARB_IDLE_TIMER);
    end else if (own_q == RARB_OWN_HOST || chDevRw[ch]) begin
      rwOe_q  <= 1'b0;
      rwOut_q <= 1'b1;
    end else begin
      rwOe_q  <= 1'b1;
      rwOut_q <= ~chWrite[ch];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stopOut_q <= 1'b0;
      stopOe_q  <= 1'b1;
    end else if (own_q == RARB_OWN_NONE) begin
      stopOe_q  <= 1'b1;
      stopOut_q <= (idle_q != RARB_IDLE_INACTIVE);
    end else if (own_q == RARB_OWN_HOST) begin
      stopOe_q  <= 1'b0;
      stopOut_q <= 1'b1;
    end else begin
      stopOe_q  <= lastCyc[ch] || !chDevStop[ch];
      stopOut_q <= !lastCyc[ch];
    end
  end
  assign bus.ackEnable_n    = ackN_q;
  assign bus.grant_code_msb = code_q[1];
  assign bus.grant_code_lsb = code_q[0];
  assign bus.dramMuxAddr    = addr_q;
  assign bus.rwDevOut       = rwOut_q;
  assign bus.rwDevOe        = rwOe_q;
  assign bus.stopDevOut     = stopOut_q;
  assign bus.stopDevOe      = stopOe_q;
endmodule : rarb_device

/* File: hdl/rarb_requester.sv */
// requester end: ram clock divider, request lines, rw and stop drive
`timescale 1ns/10ps
`include "rarb_map.svh"
module rarb_requester
  import rarb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  rarb_if.requester       bus,
  input  wire logic       hostReq,
  input  wire logic       hostWrite,
  input  wire logic [2:0] dmaReq,
  input  wire logic [2:0] devDrivesRw,
  input  wire logic [2:0] devWrite,
  input  wire logic [2:0] devDrivesStop,
  input  wire logic [2:0] devStop,
  output logic            hostGranted,
  output logic [2:0]      dmaGranted
);
  // ==========================================
  // ram clock made here by division of ref_clk
  logic [3:0] div_q;
  logic       ramClk_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q    <= '0;
      ramClk_q <= 1'b0;
    end else if (div_q == `RARB_REFRESH_DIV - 4'h1) begin
      div_q    <= '0;
      ramClk_q <= ~ramClk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign bus.ramClk = ramClk_q;

  // ==========================================
  // request lines, active low
  logic [3:0] req_q;
  always_ff @(posedge ref_clk) begin
    if (srst) req_q <= 4'hF;
    else      req_q <= ~{dmaReq, hostReq};
  end
  assign {bus.dma_req_high_pri_n, bus.dma_req_mid_pri_n,
          bus.dma_req_low_pri_n, bus.host_ram_request_n} = req_q;

  // ==========================================
  // grant decode: pins come from device flops on this clock, so no synchroniser;
  // a synchroniser here would push the line drive into the following cycle
  logic [1:0] code;
  logic       granted;
  logic       hostNow;
  logic [2:0] dmaNow;
  assign code      = {bus.grant_code_msb, bus.grant_code_lsb};
  assign granted   = ~bus.ackEnable_n;
  assign hostNow   = granted && code == `RARB_GNT_HOST;
  assign dmaNow[2] = granted && code == `RARB_GNT_HIGH;
  assign dmaNow[1] = granted && code == `RARB_GNT_MID;
  assign dmaNow[0] = granted && code == `RARB_GNT_LOW;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hostGranted <= 1'b0;
      dmaGranted  <= '0;
    end else begin
      hostGranted <= hostNow;
      dmaGranted  <= dmaNow;
    end
  end

  // ==========================================
  // rw and stop drive in granted cycles, aligned with the grant pins
  assign bus.rwExtOe    = hostNow || |(dmaNow & devDrivesRw);
  assign bus.rwExtOut   = hostNow ? ~hostWrite : ~|(dmaNow & devWrite);
  assign bus.stopExtOe  = |(dmaNow & devDrivesStop);
  assign bus.stopExtOut = ~|(dmaNow & devStop);
endmodule : rarb_requester

/* File: dv/rarb_chk.sv */
// checker on the pin bundle between arbiter device and requesters
`timescale 1ns/10ps
module rarb_chk (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ramClk,
  input wire logic host_ram_request_n,
  input wire logic dma_req_low_pri_n,
  input wire logic dma_req_mid_pri_n,
  input wire logic dma_req_high_pri_n,
  input wire logic ackEnable_n,
  input wire logic grant_code_msb,
  input wire logic grant_code_lsb,
  input wire logic read_write_n,
  input wire logic stopLine_n,
  input wire logic rwDevOe,
  input wire logic stopDevOe
);
  // ==========================================
  // request lines as seen at each ram clock rise
  logic       rc_q, rc2_q, v;
  logic [1:0] seen_q, code;
  logic [3:0] snap_q, prev_q;
  assign code = {grant_code_msb, grant_code_lsb};
  // pins move with the rise sample, so it is skipped
  assign v = seen_q == 2'h2 && !(ramClk && !rc_q);
  always_ff @(posedge ref_clk) begin
    rc_q  <= ramClk;
    rc2_q <= rc_q;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seen_q <= 2'h0;
    end else if (ramClk && !rc_q && seen_q != 2'h2) begin
      seen_q <= seen_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (ramClk && !rc_q) begin
      snap_q <= {dma_req_high_pri_n, dma_req_mid_pri_n, dma_req_low_pri_n, host_ram_request_n};
      prev_q <= snap_q;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  high_first_a: assert property (v && !prev_q[3] |-> !ackEnable_n && code == 2'h3)
    else $error("high request passed over");
  mid_grant_a: assert property (v && !ackEnable_n && code == 2'h2 |-> prev_q[3:2] == 2'h2)
    else $error("mid grant without cause");
  low_grant_a: assert property (v && !ackEnable_n && code == 2'h1 |-> prev_q[3:1] == 3'h6)
    else $error("low grant without cause");
  host_grant_a: assert property (v && !ackEnable_n && code == 2'h0 |-> prev_q == 4'hE)
    else $error("host grant without cause");
  host_wins_a: assert property (v && prev_q == 4'hE |-> !ackEnable_n && code == 2'h0)
    else $error("host request not granted");
  grant_hold_a: assert property ($changed({ackEnable_n, code}) |->
    (ramClk && !rc_q) || (rc_q && !rc2_q)) else $error("grant moved mid cycle");
  idle_drive_a: assert property (ackEnable_n |-> stopDevOe && rwDevOe)
    else $error("idle cycle lines not driven");
  inactive_rw_a: assert property (ackEnable_n && !stopLine_n |-> read_write_n)
    else $error("inactive cycle not read");
  host_rw_a: assert property (!ackEnable_n && code == 2'h0 |-> !rwDevOe)
    else $error("device drove rw in host cycle");
endmodule : rarb_chk

/* File: dv/testbench.sv */
// bench joining device and requester ends, checked against a model
`timescale 1ns/10ps
module testbench;
  import rarb_pkg::*;
  typedef struct {rarb_owner_e o; logic rw; logic st;} rarb_exp_s;
  localparam int LIMIT = 20000;
  logic        ref_clk, srst, hostReq, hostWrite, timerDue, hostGranted, isRef;
  logic [2:0]  dmaReq, devRw, devWrite, chStart, chWrite, en, chEnabled, chDone, dmaGranted;
  logic [47:0] chCount;
  logic [15:0] rowColAddr;
  logic [7:0]  refreshAddr, timerCount;
  logic [31:0] rng;
  rarb_owner_e owner, lastO;
  rarb_exp_s   q[$];
  int          error_cnt, tests_run, lastRef, cnt[3];
  rarb_if bus ();
  rarb_device u_rarb_device (.ref_clk, .srst, .bus, .chStart, .chCount, .chDevRw(devRw),
    .chDevStop(3'h0), .chWrite, .rowColAddr, .refreshAddr, .timerCount, .timerDue,
    .chEnabled, .chDone, .owner);
  rarb_requester u_rarb_requester (.ref_clk, .srst, .bus, .hostReq, .hostWrite, .dmaReq,
    .devDrivesRw(devRw), .devWrite, .devDrivesStop(3'h0), .devStop(3'h0), .hostGranted,
    .dmaGranted);
  rarb_chk u_rarb_chk (.ref_clk, .srst, .ramClk(bus.ramClk),
    .host_ram_request_n(bus.host_ram_request_n), .dma_req_low_pri_n(bus.dma_req_low_pri_n),
    .dma_req_mid_pri_n(bus.dma_req_mid_pri_n), .dma_req_high_pri_n(bus.dma_req_high_pri_n),
    .ackEnable_n(bus.ackEnable_n), .grant_code_msb(bus.grant_code_msb),
    .grant_code_lsb(bus.grant_code_lsb), .read_write_n(bus.read_write_n),
    .stopLine_n(bus.stopLine_n), .rwDevOe(bus.rwDevOe), .stopDevOe(bus.stopDevOe));
  // ==========================================
  // helpers
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : nxt
  task automatic fail(string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(rarb_exp_s e);
    tests_run++;
    lastO = e.o;
    if (owner !== e.o) fail("owner differs");
    if (e.o == RARB_OWN_NONE) begin
      if (bus.ackEnable_n !== 1'b1) fail("idle with grant");
      if ({bus.stopLine_n, bus.read_write_n} === 2'h0) fail("bad idle code");
      isRef = bus.stopLine_n & bus.read_write_n;
      if (lastRef >= 0 && isRef === lastRef[0]) fail("refresh order");
      lastRef = int'(isRef);
    end else begin
      if ({bus.ackEnable_n, bus.grant_code_msb, bus.grant_code_lsb} !== {1'b0, 2'(e.o - 1)})
        fail("grant code");
      if (bus.read_write_n !== e.rw) fail("read write level");
      if (hostGranted !== (e.o == RARB_OWN_HOST)) fail("host grant flag");
      if (dmaGranted !== ((e.o >= RARB_OWN_LOW) ? 3'h1 << (e.o - 2) : 3'h0))
        fail("dma grant flags");
      if (e.o != RARB_OWN_HOST && bus.stopLine_n !== e.st) fail("stop level");
    end
  endtask : check
  // one ram clock period: predict at the rise, compare and restimulate after the fall
  task automatic step();
    rarb_exp_s   e;
    logic [31:0] r;
    int          c;
    do @(negedge ref_clk); while (bus.ramClk !== 1'b1);
    e = '{RARB_OWN_NONE, 1'b1, 1'b1};
    if (dmaReq != 3'h0) begin
      c = dmaReq[2] ? 2 : (dmaReq[1] ? 1 : 0);
      if (en[c]) begin
        e.o = rarb_owner_e'(c + 2);
        e.rw = !(devRw[c] ? devWrite[c] : chWrite[c]);
        e.st = cnt[c] != 0;
        if (cnt[c] == 0) en[c] = 1'b0;
        else cnt[c]--;
      end
    end else if (hostReq) begin
      e.o = RARB_OWN_HOST;
      e.rw = !hostWrite;
    end
    q.push_back(e);
    do @(negedge ref_clk); while (bus.ramClk !== 1'b0);
    if (q.size() > 1) check(q.pop_front());
    @(posedge ref_clk);
    #1;
    r = nxt();
    // a channel still finishing in the pins must not be reloaded
    for (int k = 0; k < 3; k++) begin
      if (!en[k] && r[k] && lastO != k + 2 && q[0].o != k + 2) begin
        chStart[k] = 1'b1;
        cnt[k] = int'(r[2*k+10 +: 2]);
        chCount[16*k +: 16] = 16'(cnt[k]);
        en[k] = 1'b1;
      end
    end
    hostReq = r[3];
    timerDue = r[4];
    dmaReq = r[7:5] & en;
    // disabled requests only on the lower two channels; high always wins
    c = int'(r[17:16]) % 2;
    if (r[15:13] == 3'h0 && !en[c]) dmaReq = 3'h1 << c;
    if (q[0].o == RARB_OWN_NONE) begin
      {hostWrite, devRw, devWrite, chWrite} = r[27:18];
      {rowColAddr, refreshAddr, timerCount} = nxt();
    end
    @(posedge ref_clk);
    #1;
    chStart = 3'h0;
  endtask : step
  task automatic do_reset();
    hostReq = 1'b0;
    dmaReq = 3'h0;
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    q.delete();
    en = 3'h0;
    lastRef = -1;
    lastO = RARB_OWN_NONE;
    do @(negedge ref_clk); while (bus.ramClk !== 1'b0);
  endtask : do_reset
  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #(50 * LIMIT);
    error_cnt++;
    finish_test();
  end
  initial begin
    rng = 32'hDC78;
    {hostWrite, timerDue, devRw, devWrite, chWrite, chStart, chCount} = '0;
    {rowColAddr, refreshAddr, timerCount} = '0;
    do_reset();
    repeat (300) step();
    do_reset();
    repeat (300) step();
    finish_test();
  end
endmodule : testbench
